/* rtl/rss_exec.v */
// Chosen here: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`include "rss_defines.vh"
// What this block does
// RQ1 - rotate left without carry moves bit 7 to bit 0 and updates only N and Z.
// RQ2 - rotate right through carry puts old carry in bit 7 and old bit 0 in carry.
// RQ3 - rotate right without carry moves bit 0 to bit 7, keeps carry, updates N and Z.
// RQ4 - set register writes FFh to the location, touches no flag and has no destination bit.
// RQ5 - destination bit 0 writes W, 1 writes back to the register.
// RQ6 - access bit 0 uses the access bank, 1 takes the bank from the bank select register.
// RQ7 - extended set, access bit 0 and address up to 95 select indexed literal offset mode.
// RQ8 - sleep clears power-down, sets time-out and clears the watchdog and postscaler.
// RQ9 - in the same cycle as the status update sleep stops the oscillator and enters the sleep state.
// RQ10 - a watchdog wake from sleep clears the time-out bit.
// RQ11 - sub register from W with borrow computes W minus f minus inverted carry, all five flags.
// RQ12 - sub W from register computes f minus W to the chosen destination, all five flags.
// RQ13 - carry after a subtraction is an inverted borrow.
// RQ14 - each instruction is one word and one cycle of decode, read, process and write.
module rss_exec (
    // clock and reset
    input wire CLK,
    input wire RESET_N,
    // axi4-lite write address
    input wire [3:0] S_AXI_AWADDR,
    input wire S_AXI_AWVALID,
    output wire S_AXI_AWREADY,
    // axi4-lite write data
    input wire [31:0] S_AXI_WDATA,
    input wire [3:0] S_AXI_WSTRB,
    input wire S_AXI_WVALID,
    output wire S_AXI_WREADY,
    // axi4-lite write response
    output reg [1:0] S_AXI_BRESP,
    output reg S_AXI_BVALID,
    input wire S_AXI_BREADY,
    // axi4-lite read address
    input wire [3:0] S_AXI_ARADDR,
    input wire S_AXI_ARVALID,
    output wire S_AXI_ARREADY,
    // axi4-lite read data
    output reg [31:0] S_AXI_RDATA,
    output reg [1:0] S_AXI_RRESP,
    output reg S_AXI_RVALID,
    input wire S_AXI_RREADY,
    // data memory port
    output reg [11:0] MEM_ADDR,
    output reg MEM_RD,
    input wire [7:0] MEM_RDATA,
    output reg MEM_WR,
    output reg [7:0] MEM_WDATA,
    // indirect base for indexed mode
    input wire [7:0] FSR2_VAL,
    // watchdog and power control
    input wire WDT_WAKE,
    output reg WDT_CLEAR,
    output reg OSC_STOP
);
    localparam [3:0] ST_IDLE = 4'b0001;
    localparam [3:0] ST_READ = 4'b0010;
    localparam [3:0] ST_PROC = 4'b0100;
    localparam [3:0] ST_WRITE = 4'b1000;

    reg [3:0] state_r;
    reg [15:0] insn_r;
    reg [7:0] w_r;
    reg [7:0] f_r;
    reg [8:0] stat_r;
    reg ext_r;
    reg [3:0] bank_r;
    reg have_aw_r;
    reg have_w_r;
    reg [3:0] awaddr_r;
    reg [31:0] wdata_r;
    reg [3:0] wstrb_r;
    reg insn_go;

    wire [7:0] alu_res;
    wire [4:0] alu_flags;
    wire [4:0] alu_we;
    wire [11:0] eff_addr;
    wire sleeping = stat_r[`RSS_ST_SLEEP];

    // opcode decode, used in several places
    function [6:0] rss_decode;
        input [15:0] ins;
        begin
            rss_decode[0] = (ins[15:10] == `RSS_OP_RLNCF6);
            rss_decode[1] = (ins[15:10] == `RSS_OP_RRCF6);
            rss_decode[2] = (ins[15:10] == `RSS_OP_RRNCF6);
            rss_decode[3] = (ins[15:10] == `RSS_OP_SUBFWB6);
            rss_decode[4] = (ins[15:10] == `RSS_OP_SUBWF6);
            rss_decode[5] = (ins[15:9] == `RSS_OP_SET7);
            rss_decode[6] = (ins == `RSS_OP_SLEEP);
        end
    endfunction

    wire [6:0] dec = rss_decode(insn_r);
    wire known = |dec;
    wire dest_f = insn_r[9] | dec[5]; // see RQ4 see RQ5

    rss_alu u_alu (
        .op_rlnc(dec[0]),
        .op_rrc(dec[1]),
        .op_rrnc(dec[2]),
        .op_sub_reg_from_w_borrow(dec[3]),
        .op_sub_w_from_reg(dec[4]),
        .op_set(dec[5]),
        .f_val(f_r),
        .w_val(w_r),
        .c_in(stat_r[`RSS_ST_C]),
        .res(alu_res),
        .flags(alu_flags),
        .flag_we(alu_we)
    );

    rss_addr u_addr (
        .f_addr(insn_r[7:0]),
        .acc_bit(insn_r[8]),
        .ext_en(ext_r),
        .bank_sel(bank_r),
        .fsr2_val(FSR2_VAL),
        .mem_addr(eff_addr),
        .indexed()
    );

    // axi handshakes: one write and one read outstanding
    assign S_AXI_AWREADY = !have_aw_r && !S_AXI_BVALID;
    assign S_AXI_WREADY = !have_w_r && !S_AXI_BVALID;
    assign S_AXI_ARREADY = !S_AXI_RVALID;

    wire wr_fire = have_aw_r && have_w_r && !S_AXI_BVALID;
    wire wr_ok = (awaddr_r == `RSS_OFF_CTRL) || (awaddr_r == `RSS_OFF_INSN) ||
                 (awaddr_r == `RSS_OFF_WREG);

    // write channel capture and register writes
    always @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            have_aw_r <= 1'b0;
            have_w_r <= 1'b0;
            awaddr_r <= 4'h0;
            wdata_r <= 32'h00000000;
            wstrb_r <= 4'h0;
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP <= 2'b00;
            ext_r <= 1'b0;
            bank_r <= `RSS_RST_BANK;
            insn_r <= 16'h0000;
            insn_go <= 1'b0;
        end else begin
            insn_go <= 1'b0;
            if (S_AXI_AWVALID && S_AXI_AWREADY) begin
                have_aw_r <= 1'b1;
                awaddr_r <= {S_AXI_AWADDR[3:2], 2'b00};
            end
            if (S_AXI_WVALID && S_AXI_WREADY) begin
                have_w_r <= 1'b1;
                wdata_r <= S_AXI_WDATA;
                wstrb_r <= S_AXI_WSTRB;
            end
            if (S_AXI_BVALID && S_AXI_BREADY)
                S_AXI_BVALID <= 1'b0;
            if (wr_fire) begin
                have_aw_r <= 1'b0;
                have_w_r <= 1'b0;
                S_AXI_BVALID <= 1'b1;
                S_AXI_BRESP <= wr_ok ? 2'b00 : 2'b10;
                if (awaddr_r == `RSS_OFF_CTRL) begin
                    if (wstrb_r[0])
                        ext_r <= wdata_r[`RSS_CTRL_EXT_BIT];
                    if (wstrb_r[1])
                        bank_r <= wdata_r[`RSS_CTRL_BANK_LO+3:`RSS_CTRL_BANK_LO];
                end
                // new instruction only when idle and awake
                if (awaddr_r == `RSS_OFF_INSN && state_r == ST_IDLE && !sleeping && (&wstrb_r[1:0])) begin
                    insn_r <= wdata_r[15:0];
                    insn_go <= 1'b1;
                end
            end
        end
    end

    // read channel
    always @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            S_AXI_RVALID <= 1'b0;
            S_AXI_RDATA <= 32'h00000000;
            S_AXI_RRESP <= 2'b00;
        end else begin
            if (S_AXI_RVALID && S_AXI_RREADY)
                S_AXI_RVALID <= 1'b0;
            if (S_AXI_ARVALID && S_AXI_ARREADY) begin
                S_AXI_RVALID <= 1'b1;
                S_AXI_RRESP <= 2'b00;
                case ({S_AXI_ARADDR[3:2], 2'b00})
                    `RSS_OFF_CTRL: S_AXI_RDATA <= {20'h00000, bank_r, 7'h00, ext_r};
                    `RSS_OFF_INSN: S_AXI_RDATA <= {16'h0000, insn_r};
                    `RSS_OFF_WREG: S_AXI_RDATA <= {24'h000000, w_r};
                    `RSS_OFF_STAT: S_AXI_RDATA <= {23'h000000, state_r != ST_IDLE, stat_r[7:0]};
                    default: begin
                        S_AXI_RDATA <= 32'h00000000;
                        S_AXI_RRESP <= 2'b10;
                    end
                endcase
            end
        end
    end

    // four-phase instruction cycle: decode, read, process, write
    always @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            state_r <= ST_IDLE;
            w_r <= 8'h00;
            f_r <= 8'h00;
            stat_r <= `RSS_RST_STAT;
            MEM_ADDR <= 12'h000;
            MEM_RD <= 1'b0;
            MEM_WR <= 1'b0;
            MEM_WDATA <= 8'h00;
            WDT_CLEAR <= 1'b0;
            OSC_STOP <= 1'b0;
        end else begin
            MEM_RD <= 1'b0;
            MEM_WR <= 1'b0;
            WDT_CLEAR <= 1'b0;
            if (wr_fire && awaddr_r == `RSS_OFF_WREG && wstrb_r[0])
                w_r <= wdata_r[7:0];
            // watchdog wake leaves sleep and clears time-out
            if (sleeping && WDT_WAKE) begin
                stat_r[`RSS_ST_TO] <= 1'b0; // see RQ10
                stat_r[`RSS_ST_SLEEP] <= 1'b0;
                OSC_STOP <= 1'b0;
            end
            case (state_r)
                ST_IDLE: begin
                    if (insn_go)
                        state_r <= ST_READ; // see RQ14
                end
                ST_READ: begin
                    MEM_ADDR <= eff_addr;
                    MEM_RD <= known && !dec[6];
                    state_r <= ST_PROC;
                end
                ST_PROC: begin
                    f_r <= MEM_RDATA;
                    state_r <= ST_WRITE;
                end
                ST_WRITE: begin
                    state_r <= ST_IDLE;
                    if (dec[6]) begin
                        stat_r[`RSS_ST_PD] <= 1'b0; // see RQ8
                        stat_r[`RSS_ST_TO] <= 1'b1; // see RQ8
                        WDT_CLEAR <= 1'b1; // see RQ8
                        stat_r[`RSS_ST_SLEEP] <= 1'b1; // see RQ9
                        OSC_STOP <= 1'b1; // see RQ9
                    end else if (known) begin
                        if (dest_f) begin
                            MEM_WR <= 1'b1; // see RQ5
                            MEM_WDATA <= alu_res;
                        end else begin
                            w_r <= alu_res; // see RQ5
                        end
                        stat_r[4:0] <= (stat_r[4:0] & ~alu_we) | (alu_flags & alu_we);
                    end
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end
endmodule // rss_exec

/* rtl/rss_defines.vh */
`ifndef RSS_DEFINES_VH
`define RSS_DEFINES_VH
// axi-lite register byte offsets
`define RSS_OFF_CTRL 4'h0
`define RSS_OFF_INSN 4'h4
`define RSS_OFF_WREG 4'h8
`define RSS_OFF_STAT 4'hC
// control register fields
`define RSS_CTRL_EXT_BIT 0
`define RSS_CTRL_BANK_LO 8
// status register fields
`define RSS_ST_C 0
`define RSS_ST_DC 1
`define RSS_ST_Z 2
`define RSS_ST_OV 3
`define RSS_ST_N 4
`define RSS_ST_PD 5
`define RSS_ST_TO 6
`define RSS_ST_SLEEP 7
`define RSS_ST_BUSY 8
// opcode fields, upper bits of the 16-bit word; sleep is the whole word
`define RSS_OP_RLNCF6 6'h11
`define RSS_OP_RRCF6 6'h0C
`define RSS_OP_RRNCF6 6'h10
`define RSS_OP_SUBFWB6 6'h15
`define RSS_OP_SUBWF6 6'h17
`define RSS_OP_SET7 7'h34
`define RSS_OP_SLEEP 16'h0003
// indexed literal offset limit, 95
`define RSS_IDX_MAX 8'h5F
// access bank upper part base
`define RSS_ACC_HI 8'h60
// reset values
`define RSS_RST_STAT 9'h060
`define RSS_RST_BANK 4'h0
`endif

/* rtl/rss_alu.v */
`timescale 1ns/1ps
`include "rss_defines.vh"
module rss_alu (
    // operation select, one-hot
    input wire op_rlnc,
    input wire op_rrc,
    input wire op_rrnc,
    input wire op_sub_reg_from_w_borrow,
    input wire op_sub_w_from_reg,
    input wire op_set,
    // operands
    input wire [7:0] f_val,
    input wire [7:0] w_val,
    input wire c_in,
    // results
    output reg [7:0] res,
    output reg [4:0] flags,
    output reg [4:0] flag_we
);
    reg [8:0] diff;
    reg [4:0] nib;
    reg [7:0] a;
    reg [7:0] b;
    reg bin;
    // rotate and subtract datapath; subtraction as a + ~b + carry
    always @* begin
        a = op_sub_reg_from_w_borrow ? w_val : f_val;
        b = op_sub_reg_from_w_borrow ? f_val : w_val;
        bin = op_sub_reg_from_w_borrow ? c_in : 1'b1;
        diff = {1'b0, a} + {1'b0, ~b} + {8'h00, bin};
        nib = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + {4'h0, bin};
        res = 8'h00;
        flags = 5'h00;
        flag_we = 5'h00;
        if (op_rlnc) begin
            res = {f_val[6:0], f_val[7]}; // see RQ1
            flag_we = 5'h14;
        end else if (op_rrc) begin
            res = {c_in, f_val[7:1]}; // see RQ2
            flags[`RSS_ST_C] = f_val[0];
            flag_we = 5'h15;
        end else if (op_rrnc) begin
            res = {f_val[0], f_val[7:1]}; // see RQ3
            flag_we = 5'h14;
        end else if (op_sub_reg_from_w_borrow || op_sub_w_from_reg) begin
            res = diff[7:0]; // see RQ11 see RQ12
            flags[`RSS_ST_C] = diff[8]; // see RQ13
            flags[`RSS_ST_DC] = nib[4];
            flags[`RSS_ST_OV] = (a[7] != b[7]) && (diff[7] != a[7]);
            flag_we = 5'h1F;
        end else if (op_set) begin
            res = 8'hFF; // see RQ4
        end
        flags[`RSS_ST_Z] = (res == 8'h00);
        flags[`RSS_ST_N] = res[7];
    end
endmodule // rss_alu

/* rtl/rss_addr.v */
`timescale 1ns/1ps
`include "rss_defines.vh"
module rss_addr (
    // operand fields
    input wire [7:0] f_addr,
    input wire acc_bit,
    input wire ext_en,
    input wire [3:0] bank_sel,
    input wire [7:0] fsr2_val,
    // resolved data memory address
    output reg [11:0] mem_addr,
    output reg indexed
);
    // bank selection and indexed literal offset mode
    always @* begin
        indexed = ext_en && !acc_bit && (f_addr <= `RSS_IDX_MAX); // see RQ7
        if (indexed) begin
            mem_addr = {4'h0, fsr2_val + f_addr};
        end else if (!acc_bit) begin
            mem_addr = (f_addr >= `RSS_ACC_HI) ? {4'hF, f_addr} : {4'h0, f_addr}; // see RQ6
        end else begin
            mem_addr = {bank_sel, f_addr}; // see RQ6
        end
    end
endmodule // rss_addr

/* tb/rss_exec_props.sv */
`timescale 1ns/1ps
module rss_exec_chk (
    // clock and reset
    input wire CLK,
    input wire RESET_N,
    // bus handshakes
    input wire S_AXI_AWVALID,
    input wire S_AXI_AWREADY,
    input wire S_AXI_WVALID,
    input wire S_AXI_WREADY,
    input wire S_AXI_BVALID,
    input wire S_AXI_ARVALID,
    input wire S_AXI_ARREADY,
    input wire S_AXI_RVALID,
    // memory and power
    input wire [11:0] MEM_ADDR,
    input wire MEM_RD,
    input wire MEM_WR,
    input wire WDT_WAKE,
    input wire WDT_CLEAR,
    input wire OSC_STOP
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESET_N);
    // steps of the sleep entry
    sequence s_clr_done; ##1 !WDT_CLEAR; endsequence
    sequence s_osc_off; ##[0:4] OSC_STOP; endsequence
    // both halves taken at one edge: the pair is held one cycle, then the response stands
    property p_bvalid; S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY |-> ##2 S_AXI_BVALID; endproperty
    property p_rvalid; S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID; endproperty
    property p_wdt_pulse; WDT_CLEAR |-> s_clr_done; endproperty
    property p_sleep; WDT_CLEAR |-> s_osc_off; endproperty
    property p_stay; OSC_STOP && !WDT_WAKE |=> OSC_STOP; endproperty
    property p_wake; OSC_STOP && WDT_WAKE |-> ##[1:3] !OSC_STOP; endproperty
    property p_wrback; MEM_WR |-> $past(MEM_RD, 2) && $stable(MEM_ADDR); endproperty
    property p_rd_pulse; MEM_RD |=> !MEM_RD; endproperty
    a_bvalid: assert property (p_bvalid) else $error("write response late");
    a_rvalid: assert property (p_rvalid) else $error("read data late");
    a_wdt_pulse: assert property (p_wdt_pulse) else $error("watchdog clear too long");
    a_sleep: assert property (p_sleep) else $error("oscillator not stopped");
    a_stay: assert property (p_stay) else $error("left sleep without wake");
    a_wake: assert property (p_wake) else $error("no wake from sleep");
    a_wrback: assert property (p_wrback) else $error("write back out of step");
    a_rd_pulse: assert property (p_rd_pulse) else $error("read strobe too long");
endmodule // rss_exec_chk
bind rss_exec rss_exec_chk u_chk (.*);

/* tb/rss_exec_tb.sv */
`timescale 1ns/1ps
module testbench;
    reg clk = 1'b0, rst_n = 1'b0, aw_v = 1'b0, w_v = 1'b0, b_r = 1'b0, ar_v = 1'b0, r_r = 1'b0, wake = 1'b0;
    reg [3:0] awaddr = 4'h0, araddr = 4'h0;
    reg [31:0] wdata = 32'h0;
    reg [7:0] f_val = 8'h00;
    reg wr_seen = 1'b0, clr_seen = 1'b0;
    reg [7:0] wr_data = 8'h00;
    reg [11:0] wr_addr = 12'h000;
    wire aw_rdy, w_rdy, b_v, ar_rdy, r_v, mem_rd, mem_wr, wdt_clr, osc_stop;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    wire [11:0] mem_addr;
    wire [7:0] mem_wdata;
    integer err_count = 0, cmp_count = 0;
    rss_exec DUT (.CLK(clk), .RESET_N(rst_n), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(aw_v), .S_AXI_AWREADY(aw_rdy),
        .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(w_v), .S_AXI_WREADY(w_rdy), .S_AXI_BRESP(bresp),
        .S_AXI_BVALID(b_v), .S_AXI_BREADY(b_r), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(ar_v), .S_AXI_ARREADY(ar_rdy),
        .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(r_v), .S_AXI_RREADY(r_r), .MEM_ADDR(mem_addr),
        .MEM_RD(mem_rd), .MEM_RDATA(mem_rd ? f_val : ~f_val), .MEM_WR(mem_wr), .MEM_WDATA(mem_wdata),
        .FSR2_VAL(8'h30), .WDT_WAKE(wake), .WDT_CLEAR(wdt_clr), .OSC_STOP(osc_stop));
    // clock and memory write monitor
    always #20 clk = ~clk;
    always @(posedge clk) begin
        if (mem_wr) begin
            wr_seen <= 1'b1;
            wr_data <= mem_wdata;
            wr_addr <= mem_addr;
        end
        if (wdt_clr) clr_seen <= 1'b1;
    end
    task close_out;
        $display("compares %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task check(input string what, input [31:0] exp, input [31:0] got);
        cmp_count = cmp_count + 1;
        if (got !== exp) begin
            err_count = err_count + 1;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    // a wait that ran out ends the run
    task guard(input integer n);
        if (n >= 50) begin
            check("handshake", 1, 0);
            close_out;
        end
    endtask
    task axw(input [3:0] a, input [31:0] d, output [1:0] r);
        integer n;
        reg pa, pw;
        @(posedge clk);
        aw_v <= 1'b1; w_v <= 1'b1; awaddr <= a; wdata <= d; b_r <= 1'b1;
        pa = 1'b1; pw = 1'b1; n = 0;
        do begin
            @(posedge clk);
            n = n + 1;
            if (pa && aw_rdy === 1'b1) begin pa = 1'b0; aw_v <= 1'b0; end
            if (pw && w_rdy === 1'b1) begin pw = 1'b0; w_v <= 1'b0; end
        end while (b_v !== 1'b1 && n < 50);
        guard(n);
        r = bresp;
        b_r <= 1'b0;
    endtask
    task axr(input [3:0] a, output [31:0] d);
        integer n;
        reg pa;
        @(posedge clk);
        ar_v <= 1'b1; araddr <= a; r_r <= 1'b1;
        pa = 1'b1; n = 0;
        do begin
            @(posedge clk);
            n = n + 1;
            if (pa && ar_rdy === 1'b1) begin pa = 1'b0; ar_v <= 1'b0; end
        end while (r_v !== 1'b1 && n < 50);
        guard(n);
        d = rdata;
        check("read resp", 2'b00, rresp);
        r_r <= 1'b0;
    endtask
    // one instruction through the register port, then status
    task run(input [15:0] ins, input [7:0] f, output [31:0] s);
        reg [1:0] r;
        f_val <= f;
        wr_seen <= 1'b0;
        axw(4'h4, {16'h0, ins}, r);
        check("insn resp", 2'b00, r);
        repeat (5) @(posedge clk);
        axr(4'hC, s);
        check("busy", 1'b0, s[8]);
    endtask
    task t_reset;
        reg [31:0] d;
        axr(4'hC, d);
        check("stat reset", 32'h060, d);
        axr(4'h0, d);
        check("ctrl reset", 32'h0, d);
        $display("reset test done");
    endtask
    task t_alu;
        reg [15:0] ins [0:7];
        reg [7:0] fv [0:7], res [0:7], st [0:7];
        reg [31:0] s, d;
        reg [1:0] r;
        integer i;
        ins = '{16'h5E20, 16'h4620, 16'h3220, 16'h5620, 16'h5E20, 16'h5E20, 16'h6820, 16'h4020};
        fv = '{8'h03, 8'hAB, 8'hE6, 8'h03, 8'h02, 8'h80, 8'h5A, 8'hD7};
        res = '{8'h01, 8'h57, 8'hF3, 8'hFE, 8'h00, 8'h7E, 8'hFF, 8'hEB};
        st = '{8'h03, 8'h03, 8'h12, 8'h10, 8'h07, 8'h09, 8'h09, 8'h19};
        axw(4'h8, 32'h2, r);
        for (i = 0; i < 8; i = i + 1) begin
            run(ins[i], fv[i], s);
            check("flags", st[i][4:0], s[4:0]);
            if (ins[i][9] || ins[i][15:9] == 7'h34) begin
                check("mem data", res[i], wr_data);
                check("mem addr", 12'h020, wr_addr);
            end else begin
                axr(4'h8, d);
                check("w result", res[i], d);
                check("no mem write", 1'b0, wr_seen);
            end
        end
        $display("alu test done");
    endtask
    task t_addr;
        reg [31:0] cv [0:4], s, d;
        reg [15:0] ins [0:4];
        reg [11:0] ea [0:4];
        reg [1:0] r;
        integer i;
        cv = '{32'h500, 32'h500, 32'h501, 32'h501, 32'h501};
        ins = '{16'h6912, 16'h6812, 16'h685F, 16'h6860, 16'h6912};
        ea = '{12'h512, 12'h012, 12'h08F, 12'hF60, 12'h512};
        for (i = 0; i < 5; i = i + 1) begin
            axw(4'h0, cv[i], r);
            axr(4'h0, d);
            check("ctrl", cv[i], d);
            run(ins[i], 8'h00, s);
            check("address", ea[i], wr_addr);
        end
        $display("address test done");
    endtask
    task t_sleep;
        reg [31:0] s, d;
        reg [1:0] r;
        clr_seen <= 1'b0;
        run(16'h0003, 8'h00, s);
        check("sleep stat", 3'b110, s[7:5]);
        check("wdt clear", 1'b1, clr_seen);
        check("osc stop", 1'b1, osc_stop);
        run(16'h6812, 8'h00, s);
        check("asleep write", 1'b0, wr_seen);
        @(posedge clk);
        wake <= 1'b1;
        @(posedge clk);
        wake <= 1'b0;
        repeat (3) @(posedge clk);
        check("osc run", 1'b0, osc_stop);
        axr(4'hC, s);
        check("wake stat", 3'b000, s[7:5]);
        // second sleep starts from a cleared time-out bit, so the set is visible
        run(16'h0003, 8'h00, s);
        check("resleep stat", 3'b110, s[7:5]);
        @(posedge clk);
        wake <= 1'b1;
        @(posedge clk);
        wake <= 1'b0;
        repeat (3) @(posedge clk);
        axr(4'hC, s);
        check("rewake stat", 3'b000, s[7:5]);
        axw(4'hC, 32'hFF, r);
        check("stat write resp", 2'b10, r);
        axr(4'hC, d);
        check("stat kept", s, d);
        $display("sleep test done");
    endtask
    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        t_reset;
        t_alu;
        t_addr;
        t_sleep;
        close_out;
    end
endmodule // testbench
